// ==== logic/dcf_pkg.sv ====
package dcf_pkg;

   // Storage geometry
   localparam int DATA_W = 9;
   localparam int ADDR_W = 16;
   localparam int PTR_W  = 18;
   localparam int OFF_W  = 16;

   // Depth limits seen by the writer, per timing mode
   localparam logic [PTR_W-1:0] DEPTH_STD  = 18'h10000;
   localparam logic [PTR_W-1:0] DEPTH_FALL_THROUGH_MODE = 18'h10001;
   localparam logic [PTR_W-1:0] HALF_STD   = 18'h08000;
   localparam logic [PTR_W-1:0] HALF_FALL_THROUGH_MODE  = 18'h08001;

   // Offset defaults chosen by the load control level at master reset
   localparam logic [OFF_W-1:0] OFF_DEF_PAR = 16'h007f;
   localparam logic [OFF_W-1:0] OFF_DEF_SER = 16'h03ff;

   // Offset word layout: {full offset, empty offset}, each as a low and a high part
   localparam int OFF_LO_W  = 9;
   localparam int OFF_HI_W  = 7;
   localparam int FULL_BASE = 16;
   localparam logic [1:0] STEP_RST = 2'h0;

   // Positions in the bundle of synchronised pins
   localparam int PIN_W    = 19;
   localparam int PIN_WCLK = 18;
   localparam int PIN_RCLK = 17;
   localparam int PIN_WEN  = 16;
   localparam int PIN_REN  = 15;
   localparam int PIN_MRS  = 14;
   localparam int PIN_PRS  = 13;
   localparam int PIN_SI   = 12;
   localparam int PIN_LD   = 11;
   localparam int PIN_SEN  = 10;
   localparam int PIN_RT   = 9;

   // Retransmit setup time
   localparam int CLK_PERIOD_NS = 25;
   localparam int RT_SETUP_NS   = 60;
   localparam int RT_CNT_W      = 3;
   localparam logic [RT_CNT_W-1:0] RT_SETUP_CYC =
      RT_CNT_W'((RT_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [RT_CNT_W-1:0] RT_CNT_RST = 3'h0;
   localparam logic [RT_CNT_W-1:0] RT_CNT_ONE = 3'h1;

   typedef enum logic [1:0] {
      DCF_RT_IDLE  = 2'b00,
      DCF_RT_COUNT = 2'b01,
      DCF_RT_EDGE  = 2'b10
   } dcf_rt_state_t;

endpackage

// ==== logic/dcf_sync.sv ====
`timescale 1ns/1ps
// Two flip-flop synchroniser; only the second stage is visible
module dcf_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] stage1;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         stage1 <= '0;
         q      <= '0;
      end else begin
         stage1 <= d;
         q      <= stage1;
      end
   end

endmodule

// ==== logic/dcf_fifo.sv ====
`timescale 1ns/1ps
module dcf_fifo (
   input  wire logic                       clk_sys,
   input  wire logic                       rst_n,
   input  wire logic                       wr_clk,
   input  wire logic                       rd_clk,
   input  wire logic                       wr_en_n,
   input  wire logic                       rd_en_n,
   input  wire logic [dcf_pkg::DATA_W-1:0] write_data,
   input  wire logic                       master_reset_n,
   input  wire logic                       partial_reset_n,
   input  wire logic                       mode_select_serial_in,
   input  wire logic                       offset_load_ctl,
   input  wire logic                       serial_en_n,
   input  wire logic                       retransmit_n,
   output logic      [dcf_pkg::DATA_W-1:0] read_data_out,
   output logic                            full_flag_n,
   output logic                            empty_flag_n,
   output logic                            almost_full_flag,
   output logic                            almost_empty_flag,
   output logic                            half_full_flag_n
);

   localparam int PW = dcf_pkg::PTR_W;
   localparam int OW = dcf_pkg::OFF_W;

   logic [dcf_pkg::PIN_W-1:0]  pins_s;
   logic                       wclk_q;
   logic                       rclk_q;
   logic [dcf_pkg::DATA_W-1:0] mem [0:(1 << dcf_pkg::ADDR_W)-1];

   // Write-side state
   logic                       mode_fall_through_mode;
   logic                       serial_load;
   logic [2*OW-1:0]            offs;
   logic [1:0]                 wstep;
   logic [PW-1:0]              wptr;
   logic                       full_stage;
   logic                       next_mode_fall_through_mode;
   logic                       next_serial_load;
   logic [2*OW-1:0]            next_offs;
   logic [1:0]                 next_wstep;
   logic [PW-1:0]              next_wptr;
   logic                       next_full_stage;
   logic                       next_full_flag_n;
   logic                       next_almost_full_flag;

   // Read-side state
   logic [PW-1:0]              rptr;
   logic                       out_valid;
   logic                       avail_s1;
   logic                       avail_s2;
   logic [1:0]                 rstep;
   dcf_pkg::dcf_rt_state_t     rt_state;
   logic [dcf_pkg::RT_CNT_W-1:0] rt_cnt;
   logic [PW-1:0]              next_rptr;
   logic                       next_out_valid;
   logic                       next_avail_s1;
   logic                       next_avail_s2;
   logic [1:0]                 next_rstep;
   dcf_pkg::dcf_rt_state_t     next_rt_state;
   logic [dcf_pkg::RT_CNT_W-1:0] next_rt_cnt;
   logic [dcf_pkg::DATA_W-1:0] next_read_data_out;
   logic                       next_empty_flag_n;
   logic                       next_almost_empty_flag;
   logic                       next_half_full_flag_n;

   // Cross-side views and derived terms
   logic [PW:0]                rview_s;
   logic [PW-1:0]              wptr_r;
   logic [PW-1:0]              rptr_w;
   logic [PW-1:0]              occ_w;
   logic [PW-1:0]              occ_w_next;
   logic [PW-1:0]              mem_w;
   logic [PW-1:0]              mem_r;
   logic [PW-1:0]              limit_w;
   logic [PW-1:0]              half_lvl;
   logic                       w_edge;
   logic                       r_edge;
   logic                       in_reset;
   logic                       wr_fire;
   logic                       full_now;
   logic                       hf_set;
   logic                       ld_s;
   logic                       si_s;
   logic [dcf_pkg::DATA_W-1:0] wdata_s;

   // All pins are asynchronous to clk_sys, including both link clocks
   dcf_sync #(.W(dcf_pkg::PIN_W)) u_pin_sync (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .d       ({wr_clk, rd_clk, wr_en_n, rd_en_n, master_reset_n, partial_reset_n,
                 mode_select_serial_in, offset_load_ctl, serial_en_n, retransmit_n,
                 write_data}),
      .q       (pins_s)
   );

   // Read pointer and output-register valid bit handed to the write side
   dcf_sync #(.W(PW + 1)) u_rd_to_wr (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .d       ({out_valid, rptr}),
      .q       (rview_s)
   );

   // Write pointer handed to the read side
   dcf_sync #(.W(PW)) u_wr_to_rd (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .d       (wptr),
      .q       (wptr_r)
   );

   // Both views lag, so every flag but half-full is pessimistic and never lets a side overrun
   assign rptr_w   = rview_s[PW-1:0];
   assign ld_s     = pins_s[dcf_pkg::PIN_LD];
   assign si_s     = pins_s[dcf_pkg::PIN_SI];
   assign wdata_s  = pins_s[dcf_pkg::DATA_W-1:0];
   assign in_reset = !pins_s[dcf_pkg::PIN_MRS] || !pins_s[dcf_pkg::PIN_PRS];
   assign w_edge   = pins_s[dcf_pkg::PIN_WCLK] && !wclk_q;
   assign r_edge   = pins_s[dcf_pkg::PIN_RCLK] && !rclk_q;
   assign occ_w    = wptr - (rptr_w - PW'(rview_s[PW]));
   assign mem_w    = wptr - rptr_w;
   assign mem_r    = wptr_r - rptr;
   assign limit_w  = mode_fall_through_mode ? dcf_pkg::DEPTH_FALL_THROUGH_MODE : dcf_pkg::DEPTH_STD;
   assign half_lvl = mode_fall_through_mode ? dcf_pkg::HALF_FALL_THROUGH_MODE : dcf_pkg::HALF_STD;
   // Memory itself also bounded: before fall-through the output register is empty
   assign wr_fire  = w_edge && !in_reset && ld_s && !pins_s[dcf_pkg::PIN_WEN]
                     && (occ_w < limit_w) && (mem_w < dcf_pkg::DEPTH_STD);
   assign occ_w_next = occ_w + PW'(wr_fire);
   assign full_now = occ_w_next >= limit_w;
   assign hf_set   = w_edge && !in_reset && (occ_w_next > half_lvl);

   // Edge detectors look at the second synchroniser stage only
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wclk_q <= 1'b0;
         rclk_q <= 1'b0;
      end else begin
         wclk_q <= pins_s[dcf_pkg::PIN_WCLK];
         rclk_q <= pins_s[dcf_pkg::PIN_RCLK];
      end
   end

   // Storage, no reset needed for data words
   always_ff @(posedge clk_sys) begin
      if (wr_fire) begin
         mem[wptr[dcf_pkg::ADDR_W-1:0]] <= wdata_s;
      end
   end

   // Write side: pointer, mode capture, offsets, full and almost-full
   always_comb begin
      next_mode_fall_through_mode        = mode_fall_through_mode;
      next_serial_load      = serial_load;
      next_offs             = offs;
      next_wstep            = wstep;
      next_wptr             = wptr;
      next_full_stage       = full_stage;
      next_full_flag_n      = full_flag_n;
      next_almost_full_flag = almost_full_flag;
      if (!pins_s[dcf_pkg::PIN_MRS]) begin
         next_mode_fall_through_mode   = si_s;
         next_serial_load = ld_s;
         if (ld_s) begin
            next_offs = {dcf_pkg::OFF_DEF_SER, dcf_pkg::OFF_DEF_SER};
         end else begin
            next_offs = {dcf_pkg::OFF_DEF_PAR, dcf_pkg::OFF_DEF_PAR};
         end
      end
      if (in_reset) begin
         next_wptr             = '0;
         next_wstep            = dcf_pkg::STEP_RST;
         next_full_stage       = 1'b0;
         next_full_flag_n      = !next_mode_fall_through_mode;
         next_almost_full_flag = 1'b1;
      end else if (w_edge) begin
         next_wptr       = wptr + PW'(wr_fire);
         next_full_stage = full_now;
         // Assert at once, release only when both stages agree
         next_full_flag_n = (full_now || full_stage) ? mode_fall_through_mode : !mode_fall_through_mode;
         next_almost_full_flag =
            !(occ_w_next >= limit_w - {{(PW-OW){1'b0}}, offs[2*OW-1:OW]});
         // Offset programming, only by the method fixed at master reset
         if (ld_s) begin
            next_wstep = dcf_pkg::STEP_RST;
         end else if (serial_load) begin
            if (!pins_s[dcf_pkg::PIN_SEN]) begin
               next_offs = {si_s, offs[2*OW-1:1]};
            end
         end else if (!pins_s[dcf_pkg::PIN_WEN]) begin
            next_wstep = wstep + 2'h1;
            unique case (wstep)
               2'h0: next_offs[dcf_pkg::OFF_LO_W-1:0] = wdata_s;
               2'h1: next_offs[OW-1:dcf_pkg::OFF_LO_W] = wdata_s[dcf_pkg::OFF_HI_W-1:0];
               2'h2: next_offs[dcf_pkg::FULL_BASE +: dcf_pkg::OFF_LO_W] = wdata_s;
               2'h3: next_offs[2*OW-1:dcf_pkg::FULL_BASE + dcf_pkg::OFF_LO_W] =
                        wdata_s[dcf_pkg::OFF_HI_W-1:0];
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mode_fall_through_mode        <= 1'b0;
         serial_load      <= 1'b0;
         offs             <= {dcf_pkg::OFF_DEF_PAR, dcf_pkg::OFF_DEF_PAR};
         wstep            <= dcf_pkg::STEP_RST;
         wptr             <= '0;
         full_stage       <= 1'b0;
         full_flag_n      <= 1'b1;
         almost_full_flag <= 1'b1;
      end else begin
         mode_fall_through_mode        <= next_mode_fall_through_mode;
         serial_load      <= next_serial_load;
         offs             <= next_offs;
         wstep            <= next_wstep;
         wptr             <= next_wptr;
         full_stage       <= next_full_stage;
         full_flag_n      <= next_full_flag_n;
         almost_full_flag <= next_almost_full_flag;
      end
   end

   // Read side: pointer, output register, empty, almost-empty, half-full, retransmit
   always_comb begin
      logic [PW-1:0] mem_after;
      logic [PW-1:0] cnt_after;
      mem_after              = mem_r;
      cnt_after              = '0;
      next_rptr              = rptr;
      next_out_valid         = out_valid;
      next_avail_s1          = avail_s1;
      next_avail_s2          = avail_s2;
      next_rstep             = rstep;
      next_rt_state          = rt_state;
      next_rt_cnt            = rt_cnt;
      next_read_data_out     = read_data_out;
      next_empty_flag_n      = empty_flag_n;
      next_almost_empty_flag = almost_empty_flag;
      next_half_full_flag_n  = half_full_flag_n;
      if (in_reset) begin
         next_rptr              = '0;
         next_out_valid         = 1'b0;
         next_avail_s1          = 1'b0;
         next_avail_s2          = 1'b0;
         next_rstep             = dcf_pkg::STEP_RST;
         next_rt_state          = dcf_pkg::DCF_RT_IDLE;
         next_rt_cnt            = dcf_pkg::RT_CNT_RST;
         next_empty_flag_n      = mode_fall_through_mode;
         next_almost_empty_flag = 1'b0;
         next_half_full_flag_n  = 1'b1;
      end else begin
         unique case (rt_state)
            dcf_pkg::DCF_RT_IDLE: begin
               if (r_edge && !pins_s[dcf_pkg::PIN_RT]) begin
                  // Rewind to the first location; flag shows not-ready during setup
                  next_rptr         = '0;
                  next_out_valid    = 1'b0;
                  next_avail_s1     = 1'b0;
                  next_avail_s2     = 1'b0;
                  next_empty_flag_n = mode_fall_through_mode;
                  next_rt_state     = dcf_pkg::DCF_RT_COUNT;
                  next_rt_cnt       = dcf_pkg::RT_SETUP_CYC;
               end else if (r_edge) begin
                  if (!ld_s) begin
                     if (!pins_s[dcf_pkg::PIN_REN]) begin
                        next_rstep = rstep + 2'h1;
                        unique case (rstep)
                           2'h0: next_read_data_out = offs[dcf_pkg::OFF_LO_W-1:0];
                           2'h1: next_read_data_out = {2'h0, offs[OW-1:dcf_pkg::OFF_LO_W]};
                           2'h2: next_read_data_out =
                                    offs[dcf_pkg::FULL_BASE +: dcf_pkg::OFF_LO_W];
                           2'h3: next_read_data_out =
                                    {2'h0, offs[2*OW-1:dcf_pkg::FULL_BASE + dcf_pkg::OFF_LO_W]};
                        endcase
                     end
                  end else begin
                     next_rstep = dcf_pkg::STEP_RST;
                     if (!mode_fall_through_mode) begin
                        if (!pins_s[dcf_pkg::PIN_REN] && empty_flag_n && (mem_r != '0)) begin
                           next_read_data_out = mem[rptr[dcf_pkg::ADDR_W-1:0]];
                           next_rptr          = rptr + PW'(1);
                        end
                     end else if (avail_s2 && (mem_r != '0)
                                  && (!out_valid || !pins_s[dcf_pkg::PIN_REN])) begin
                        next_read_data_out = mem[rptr[dcf_pkg::ADDR_W-1:0]];
                        next_rptr          = rptr + PW'(1);
                        next_out_valid     = 1'b1;
                     end else if (!pins_s[dcf_pkg::PIN_REN]) begin
                        next_out_valid = 1'b0;
                     end
                  end
                  mem_after     = wptr_r - next_rptr;
                  next_avail_s1 = (mem_after != '0);
                  next_avail_s2 = avail_s1 && (mem_after != '0);
                  if (mode_fall_through_mode) begin
                     next_empty_flag_n = !next_out_valid;
                  end else begin
                     next_empty_flag_n = (mem_after != '0) && avail_s1;
                  end
               end
            end
            dcf_pkg::DCF_RT_COUNT: begin
               next_rt_cnt = rt_cnt - dcf_pkg::RT_CNT_ONE;
               if (rt_cnt == dcf_pkg::RT_CNT_ONE) begin
                  next_rt_state = dcf_pkg::DCF_RT_EDGE;
               end
            end
            dcf_pkg::DCF_RT_EDGE: begin
               // Setup ends on the first read edge after the fixed delay
               if (r_edge) begin
                  next_rt_state = dcf_pkg::DCF_RT_IDLE;
                  next_avail_s1 = (mem_r != '0);
                  next_avail_s2 = (mem_r != '0);
                  if (!mode_fall_through_mode) begin
                     next_empty_flag_n = (mem_r != '0);
                  end
               end
            end
            default: begin
               next_rt_state = dcf_pkg::DCF_RT_IDLE;
            end
         endcase
         cnt_after = wptr_r - (next_rptr - PW'(next_out_valid));
         if (r_edge) begin
            next_almost_empty_flag = !(cnt_after <=
               ({{(PW-OW){1'b0}}, offs[OW-1:0]} + PW'(mode_fall_through_mode)));
         end
         // A write edge crossing half depth wins over a read edge in the same cycle
         if (hf_set) begin
            next_half_full_flag_n = 1'b0;
         end else if (r_edge && (cnt_after <= half_lvl)) begin
            next_half_full_flag_n = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rptr              <= '0;
         out_valid         <= 1'b0;
         avail_s1          <= 1'b0;
         avail_s2          <= 1'b0;
         rstep             <= dcf_pkg::STEP_RST;
         rt_state          <= dcf_pkg::DCF_RT_IDLE;
         rt_cnt            <= dcf_pkg::RT_CNT_RST;
         read_data_out     <= '0;
         empty_flag_n      <= 1'b0;
         almost_empty_flag <= 1'b0;
         half_full_flag_n  <= 1'b1;
      end else begin
         rptr              <= next_rptr;
         out_valid         <= next_out_valid;
         avail_s1          <= next_avail_s1;
         avail_s2          <= next_avail_s2;
         rstep             <= next_rstep;
         rt_state          <= next_rt_state;
         rt_cnt            <= next_rt_cnt;
         read_data_out     <= next_read_data_out;
         empty_flag_n      <= next_empty_flag_n;
         almost_empty_flag <= next_almost_empty_flag;
         half_full_flag_n  <= next_half_full_flag_n;
      end
   end

endmodule

// ==== sim/dcf_fifo_props.sv ====
`timescale 1ns/1ps
// Flag timing watcher, sees the pins only
module dcf_fifo_chk (
   input wire logic                       clk_sys,
   input wire logic                       rst_n,
   input wire logic                       wr_clk,
   input wire logic                       rd_clk,
   input wire logic                       rd_en_n,
   input wire logic                       master_reset_n,
   input wire logic                       partial_reset_n,
   input wire logic                       mode_select_serial_in,
   input wire logic [dcf_pkg::DATA_W-1:0] read_data_out,
   input wire logic                       full_flag_n,
   input wire logic                       empty_flag_n,
   input wire logic                       almost_full_flag,
   input wire logic                       almost_empty_flag,
   input wire logic                       half_full_flag_n
);
   logic [3:0] wr_age, rd_age, rs_age, next_wr_age, next_rd_age, next_rs_age;
   logic       wr_q, rd_q, ren_q, mode_q;

   // Cycles since each pin event; saturates so stale events age out
   always_comb begin
      next_wr_age = (wr_clk && !wr_q) ? 4'h0 : wr_age + {3'h0, wr_age != 4'hf};
      next_rd_age = (rd_clk && !rd_q) ? 4'h0 : rd_age + {3'h0, rd_age != 4'hf};
      next_rs_age = !(master_reset_n && partial_reset_n) ? 4'h0 : rs_age + {3'h0, rs_age != 4'hf};
   end

   // Edge memory, enable seen at the last read edge, latched mode
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         {wr_age, rd_age, rs_age} <= 12'hff0;
         {wr_q, rd_q, ren_q, mode_q} <= 4'h0;
      end else begin
         {wr_age, rd_age, rs_age} <= {next_wr_age, next_rd_age, next_rs_age};
         {wr_q, rd_q} <= {wr_clk, rd_clk};
         ren_q <= (rd_clk && !rd_q) ? rd_en_n : ren_q;
         mode_q <= master_reset_n ? mode_q : mode_select_serial_in;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   // A read edge with the enable low, seen a few cycles back
   sequence true_read;
      rd_age < 4'd9 && !ren_q;
   endsequence

   full_wr_edge_a: assert property (
      $changed(full_flag_n) |-> wr_age < 4'd9 || rs_age < 4'd9)
      else $error("full flag moved without a write edge");
   afull_wr_edge_a: assert property (
      $changed(almost_full_flag) |-> wr_age < 4'd9 || rs_age < 4'd9)
      else $error("almost full moved without a write edge");
   empty_rd_edge_a: assert property (
      $changed(empty_flag_n) |-> rd_age < 4'd9 || rs_age < 4'd9)
      else $error("empty flag moved without a read edge");
   aempty_rd_edge_a: assert property (
      $changed(almost_empty_flag) |-> rd_age < 4'd9 || rs_age < 4'd9)
      else $error("almost empty moved without a read edge");
   half_set_wr_a: assert property (
      $fell(half_full_flag_n) |-> wr_age < 4'd9)
      else $error("half full set without a write edge");
   half_clr_rd_a: assert property (
      $rose(half_full_flag_n) |-> rd_age < 4'd9 || rs_age < 4'd9)
      else $error("half full cleared without a read edge");
   data_hold_a: assert property (
      $changed(read_data_out) |-> rd_age < 4'd9 || rs_age < 4'd9)
      else $error("read data moved without a read edge");
   ready_true_read_a: assert property (
      mode_q && rs_age > 4'd8 && $rose(empty_flag_n) |-> true_read)
      else $error("output ready dropped without a true read");
   empty_on_read_a: assert property (
      !mode_q && rs_age > 4'd8 && $fell(empty_flag_n) |-> true_read)
      else $error("empty flag set without a read");
   mode_pick_a: assert property (
      (!master_reset_n && $stable(mode_select_serial_in)) [*4]
      |-> full_flag_n == !mode_select_serial_in && empty_flag_n == mode_select_serial_in)
      else $error("timing mode not shown during master reset");
endmodule

bind dcf_fifo dcf_fifo_chk i_dcf_fifo_chk (
   .clk_sys(clk_sys), .rst_n(rst_n), .wr_clk(wr_clk), .rd_clk(rd_clk), .rd_en_n(rd_en_n),
   .master_reset_n(master_reset_n), .partial_reset_n(partial_reset_n),
   .mode_select_serial_in(mode_select_serial_in), .read_data_out(read_data_out),
   .full_flag_n(full_flag_n), .empty_flag_n(empty_flag_n), .almost_full_flag(almost_full_flag),
   .almost_empty_flag(almost_empty_flag), .half_full_flag_n(half_full_flag_n));

// ==== sim/dcf_link_model.sv ====
`timescale 1ns/1ps
// Writer and reader logic; both clocks stand still between cycles
module dcf_link_model (
   input  wire logic                       clk_sys,
   output logic                            wr_clk,
   output logic                            rd_clk,
   output logic                            wr_en_n,
   output logic                            rd_en_n,
   output logic      [dcf_pkg::DATA_W-1:0] write_data
);
   // Idle levels from time zero
   initial begin
      {wr_clk, rd_clk, wr_en_n, rd_en_n} = 4'h3;
      write_data = 9'h000;
   end

   // One 200 ns write period; request held until the clock falls again
   task automatic wr_cycle(input logic en_n, input logic [dcf_pkg::DATA_W-1:0] d);
      @(negedge clk_sys);
      wr_en_n = en_n;
      write_data = d;
      repeat (3) @(negedge clk_sys);
      wr_clk = 1'b1;
      repeat (4) @(negedge clk_sys);
      wr_clk = 1'b0;
      wr_en_n = 1'b1;
      write_data = ~d;             // Released bus shows no stale word
   endtask

   // One 200 ns read period
   task automatic rd_cycle(input logic en_n);
      @(negedge clk_sys);
      rd_en_n = en_n;
      repeat (3) @(negedge clk_sys);
      rd_clk = 1'b1;
      repeat (4) @(negedge clk_sys);
      rd_clk = 1'b0;
      rd_en_n = 1'b1;
   endtask
endmodule

// ==== sim/dcf_fifo_test.sv ====
`timescale 1ns/1ps
module dcf_fifo_test;
   logic                       clk_sys, rst_n, master_reset_n, mode_select_serial_in;
   logic                       offset_load_ctl, wr_clk, rd_clk, wr_en_n, rd_en_n;
   logic                       partial_reset_n, serial_en_n, retransmit_n;
   logic [dcf_pkg::DATA_W-1:0] write_data, read_data_out;
   logic                       full_flag_n, empty_flag_n, almost_full_flag;
   logic                       almost_empty_flag, half_full_flag_n;
   int                         mismatches, tests_run;

   // Retransmit and serial shift stay idle
   dcf_fifo i_dcf_fifo (
      .clk_sys(clk_sys), .rst_n(rst_n), .wr_clk(wr_clk), .rd_clk(rd_clk), .wr_en_n(wr_en_n),
      .rd_en_n(rd_en_n), .write_data(write_data), .master_reset_n(master_reset_n),
      .partial_reset_n(partial_reset_n), .mode_select_serial_in(mode_select_serial_in),
      .offset_load_ctl(offset_load_ctl), .serial_en_n(serial_en_n), .retransmit_n(retransmit_n),
      .read_data_out(read_data_out), .full_flag_n(full_flag_n), .empty_flag_n(empty_flag_n),
      .almost_full_flag(almost_full_flag), .almost_empty_flag(almost_empty_flag),
      .half_full_flag_n(half_full_flag_n));

   dcf_link_model i_dcf_link_model (
      .clk_sys(clk_sys), .wr_clk(wr_clk), .rd_clk(rd_clk), .wr_en_n(wr_en_n),
      .rd_en_n(rd_en_n), .write_data(write_data));

   // 40 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Order: full, empty, almost full, almost empty, half full
   task automatic flags(input logic [4:0] exp);
      check("flags", 16'({full_flag_n, empty_flag_n, almost_full_flag, almost_empty_flag,
                          half_full_flag_n}), 16'(exp));
   endtask

   task automatic idle(input int n);
      repeat (n) i_dcf_link_model.rd_cycle(1'b1);
   endtask

   task automatic mreset(input logic mode, input logic ld);
      @(negedge clk_sys);
      master_reset_n = 1'b0;
      mode_select_serial_in = mode;
      offset_load_ctl = ld;
      repeat (6) @(negedge clk_sys);
      master_reset_n = 1'b1;
      offset_load_ctl = 1'b1;
      repeat (6) @(negedge clk_sys);
   endtask

   // Four parallel slices: empty low/high, full low/high
   task automatic offsets(input logic wr, input logic [15:0] e, input logic [15:0] f);
      logic [8:0] s [4];
      s = '{e[8:0], 9'(e[15:9]), f[8:0], 9'(f[15:9])};
      @(negedge clk_sys);
      offset_load_ctl = 1'b0;
      for (int i = 0; i < 4; i++) begin
         if (wr) begin
            i_dcf_link_model.wr_cycle(1'b0, s[i]);
         end else begin
            i_dcf_link_model.rd_cycle(1'b0);
            check("offset", 16'(read_data_out), 16'(s[i]));
         end
      end
      offset_load_ctl = 1'b1;
   endtask

   task automatic stop_test;
      if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // Hang guard, far past the run
   initial begin
      repeat (20000) @(posedge clk_sys);
      mismatches++;
      stop_test;
   end

   // Serial method, then standard parallel, then fall-through
   initial begin
      {rst_n, master_reset_n, mode_select_serial_in, offset_load_ctl} = 4'h1;
      {partial_reset_n, serial_en_n, retransmit_n} = 3'h7;
      {mismatches, tests_run} = '0;
      repeat (6) @(negedge clk_sys);
      rst_n = 1'b1;
      mreset(1'b0, 1'b1);
      offsets(1'b1, 16'h0001, 16'h0002);
      offsets(1'b0, 16'h03ff, 16'h03ff);
      mreset(1'b0, 1'b0);
      flags(5'b10101);
      offsets(1'b0, 16'h007f, 16'h007f);
      offsets(1'b1, 16'h0003, 16'h0205);
      offsets(1'b0, 16'h0003, 16'h0205);
      i_dcf_link_model.rd_cycle(1'b0);
      check("refused", 16'(read_data_out), 16'h0001);
      for (int i = 0; i < 4; i++) begin
         i_dcf_link_model.wr_cycle(1'b0, 9'h100 | 9'(i));
         if (i == 2) begin
            idle(2);
            flags(5'b11101);
         end
      end
      idle(2);
      flags(5'b11111);
      for (int i = 0; i < 4; i++) begin
         i_dcf_link_model.rd_cycle(1'b0);
         check("word", 16'(read_data_out), 16'h0100 | 16'(i));
      end
      flags(5'b10101);
      mreset(1'b1, 1'b0);
      flags(5'b01101);
      offsets(1'b1, 16'h0002, 16'h0205);
      for (int i = 0; i < 4; i++) i_dcf_link_model.wr_cycle(1'b0, 9'h140 | 9'(i));
      idle(2);
      check("ready", 16'(empty_flag_n), 16'h0001);
      idle(1);
      flags(5'b00111);
      check("first", 16'(read_data_out), 16'h0140);
      for (int i = 1; i < 4; i++) begin
         i_dcf_link_model.rd_cycle(1'b0);
         if (i == 1) begin
            idle(1);
            flags(5'b00101);
         end
         check("next", 16'(read_data_out), 16'h0140 | 16'(i));
      end
      flags(5'b00101);
      repeat (2) begin
         i_dcf_link_model.rd_cycle(1'b0);
         check("last", 16'(read_data_out), 16'h0143);
      end
      flags(5'b01101);
      partial_reset_n = 1'b0;
      idle(1);
      partial_reset_n = 1'b1;
      idle(1);
      offsets(1'b0, 16'h0002, 16'h0205);
      stop_test;
   end
endmodule
